// ===== rtl/track_pkg.sv
// shared constants and types for the supply tracking sequencer
package track_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_TRACK_CFG = 8'h04;
  localparam logic [7:0] ADDR_TARGET    = 8'h08;
  localparam logic [7:0] ADDR_TON_DLY   = 8'h0c;
  localparam logic [7:0] ADDR_TOFF_DLY  = 8'h10;
  localparam logic [7:0] ADDR_RISE      = 8'h14;
  localparam logic [7:0] ADDR_FALL      = 8'h18;
  localparam logic [7:0] ADDR_STATUS    = 8'h1c;
  localparam logic [7:0] ADDR_GAIN      = 8'h20;
  // track_cfg fields
  localparam int CFG_EN_BIT    = 0;
  localparam int CFG_RATIO_BIT = 1;
  localparam int CFG_LIMIT_BIT = 2;
  localparam int CFG_FOLLOW_BIT = 3;
  // ctrl fields
  localparam int CTRL_AUTOCOMP_BIT = 0;
  // clock and timing
  localparam int CLK_MHZ        = 40;
  localparam int STRAP_TON_MS   = 5;
  localparam int STRAP_TOFF_MS  = 35;
  localparam int STRAP_RISE_MS  = 2;
  localparam int CYC_PER_MS     = CLK_MHZ * 1000;
  localparam int STRAP_TON_CYC  = STRAP_TON_MS * CYC_PER_MS;
  localparam int STRAP_TOFF_CYC = STRAP_TOFF_MS * CYC_PER_MS;
  localparam int STRAP_RISE_CYC = STRAP_RISE_MS * CYC_PER_MS;
  // reset values
  localparam logic [15:0] TARGET_RST = 16'h0000;
  localparam logic [3:0]  CFG_RST    = 4'h0;
  localparam int VW = 16;
  // state machine, gray from off through off-delay, not on track to off-delay or the return to off
  typedef enum logic [2:0] {
    ST_OFF    = 3'b000,
    ST_ON_DLY = 3'b001,
    ST_TRACK  = 3'b011,
    ST_GOOD   = 3'b010,
    ST_OFF_DLY = 3'b110
  } seq_state_t;
endpackage

// ===== rtl/pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module pin_sync (
  input  wire logic clock_in,  // system clock
  input  wire logic rst_in,    // async reset
  input  wire logic ce_in,     // clock enable
  input  wire logic pin_in,    // raw pin
  output logic      level_out  // filtered level
);
  logic [2:0] s_q, s_d;
  logic       lvl_q, lvl_d;
  always_comb begin
    s_d = {s_q[1:0], pin_in};
    lvl_d = (s_q[1] == s_q[2]) ? s_q[2] : lvl_q;
  end
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      s_q <= 3'h0;
      lvl_q <= 1'b0;
    end else if (ce_in) begin
      s_q <= s_d;
      lvl_q <= lvl_d;
    end
  end
  assign level_out = lvl_q;
endmodule

// ===== rtl/strap_decode.sv
// strap code to tracking setting decoder with registered output
`timescale 1ns/100ps
module strap_decode (
  input  wire logic       clock_in,   // system clock
  input  wire logic       rst_in,     // async reset
  input  wire logic       ce_in,      // clock enable
  input  wire logic       load_in,    // capture strap now
  input  wire logic [2:0] code_in,    // strap index 0..7 (90.9k..178k)
  output logic            ratio_out,  // 1 = half ratio
  output logic            limit_out,  // 1 = limited by tracking input
  output logic            follow_out  // 1 = always follows input
);
  logic [2:0] dec_q, dec_d;
  always_comb begin
    dec_d = load_in ? code_in : dec_q; // bit2 ratio, bit1 limit, bit0 follow
  end
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) dec_q <= 3'h0;
    else if (ce_in) dec_q <= dec_d;
  end
  assign ratio_out  = dec_q[2];
  assign limit_out  = dec_q[1];
  assign follow_out = dec_q[0];
endmodule

// ===== rtl/supply_tracking_sequencer.sv
// tracking-mode turn-on/off sequencer with apb configuration
`timescale 1ns/100ps
module supply_tracking_sequencer
  import track_pkg::*;
#(
  parameter int TON_CYC  = STRAP_TON_CYC,
  parameter int TOFF_CYC = STRAP_TOFF_CYC,
  parameter int RISE_CYC = STRAP_RISE_CYC
) (
  input  wire logic          clock_in,          // 40 MHz controller clock
  input  wire logic          rst_in,            // async power-up reset
  input  wire logic          ce_in,             // clock enable
  input  wire logic          enable_pin_in,     // group enable pin
  input  wire logic [2:0]    strap_code_in,     // soft-start strap index
  input  wire logic          strap_valid_in,    // strap measurement ready
  input  wire logic [VW-1:0] follow_reference_input, // digitised tracking input
  input  wire logic [VW-1:0] vout_sense_in,     // digitised output voltage
  input  wire logic          psel,              // apb select
  input  wire logic          penable,           // apb enable
  input  wire logic          pwrite,            // apb direction
  input  wire logic [7:0]    paddr,             // apb address
  input  wire logic [31:0]   pwdata,            // apb write data
  output logic               pready,            // apb ready
  output logic [31:0]        prdata,            // apb read data
  output logic               pslverr,           // apb error
  output logic [VW-1:0]      vref_out,          // regulation reference
  output logic               drive_on_out,      // power stage enabled
  output logic               power_good_output, // output in regulation
  output logic [VW-1:0]      loop_gain_out      // ramp loop gain
);
  logic            en_sync;
  logic            s_ratio, s_limit, s_follow;
  logic            strap_done_q, strap_done_d;
  logic            strap_load;
  logic            bus_cfg_q, bus_cfg_d;
  logic [3:0]      cfg_q, cfg_d;
  logic            autocomp_q, autocomp_d;
  logic [VW-1:0]   target_q, target_d;
  logic [31:0]     ton_q, ton_d, toff_q, toff_d, rise_q, rise_d, fall_q, fall_d;
  seq_state_t      st_q, st_d;
  logic [31:0]     cnt_q, cnt_d;
  logic [VW-1:0]   vref_q, vref_d;
  logic            pg_q, pg_d;
  logic            drv_q, drv_d;
  logic [VW-1:0]   gain_q, gain_d;
  logic [31:0]     rdata_d;
  logic            wr_en;
  logic            trk_en, ratio, limit, follow;
  logic [VW-1:0]   scaled, lim_val, want;
  logic [31:0]     ton_eff, toff_eff;

  pin_sync u_en_sync (
    .clock_in  (clock_in),
    .rst_in    (rst_in),
    .ce_in     (ce_in),
    .pin_in    (enable_pin_in),
    .level_out (en_sync)
  );

  assign strap_load = strap_valid_in && !strap_done_q;
  strap_decode u_strap (
    .clock_in   (clock_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .load_in    (strap_load),
    .code_in    (strap_code_in),
    .ratio_out  (s_ratio),
    .limit_out  (s_limit),
    .follow_out (s_follow)
  );

  // effective configuration: strap until a bus write to track_cfg, then the bus word
  always_comb begin
    if (bus_cfg_q) begin
      trk_en = cfg_q[CFG_EN_BIT];
      ratio  = cfg_q[CFG_RATIO_BIT];
      limit  = cfg_q[CFG_LIMIT_BIT];
      follow = cfg_q[CFG_FOLLOW_BIT];
      ton_eff  = ton_q;
      toff_eff = toff_q;
    end else begin
      trk_en = strap_done_q;
      ratio  = s_ratio;
      limit  = s_limit;
      follow = s_follow;
      ton_eff  = TON_CYC;
      toff_eff = TOFF_CYC;
    end
  end

  // reference selection per mode
  always_comb begin
    scaled  = ratio ? (follow_reference_input >> 1) : follow_reference_input;
    lim_val = ratio ? (target_q >> 1) : target_q;
    if (limit) begin
      want = (scaled < target_q) ? scaled : target_q;
      if (!ratio) want = follow_reference_input;
    end else begin
      want = (scaled < lim_val) ? scaled : lim_val;
    end
  end

  // apb slave, zero wait states
  assign wr_en   = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  always_comb begin
    cfg_d = cfg_q;
    bus_cfg_d = bus_cfg_q;
    autocomp_d = autocomp_q;
    target_d = target_q;
    ton_d = ton_q;
    toff_d = toff_q;
    rise_d = rise_q;
    fall_d = fall_q;
    strap_done_d = strap_done_q | strap_valid_in;
    if (wr_en) begin
      if (paddr == ADDR_CTRL) begin
        autocomp_d = pwdata[CTRL_AUTOCOMP_BIT];
      end else if (paddr == ADDR_TRACK_CFG) begin
        cfg_d = pwdata[3:0];
        bus_cfg_d = 1'b1;
      end else if (paddr == ADDR_TARGET) begin
        target_d = pwdata[VW-1:0];
      end else if (paddr == ADDR_TON_DLY) begin
        ton_d = pwdata;
      end else if (paddr == ADDR_TOFF_DLY) begin
        toff_d = pwdata;
      end else if (paddr == ADDR_RISE) begin
        rise_d = pwdata;
      end else if (paddr == ADDR_FALL) begin
        fall_d = pwdata;
      end
    end
  end

  always_comb begin
    rdata_d = 32'h0;
    if (paddr == ADDR_CTRL) begin
      rdata_d = {31'h0, autocomp_q};
    end else if (paddr == ADDR_TRACK_CFG) begin
      rdata_d = {28'h0, follow, limit, ratio, trk_en};
    end else if (paddr == ADDR_TARGET) begin
      rdata_d = {16'h0, target_q};
    end else if (paddr == ADDR_TON_DLY) begin
      rdata_d = ton_eff;
    end else if (paddr == ADDR_TOFF_DLY) begin
      rdata_d = toff_eff;
    end else if (paddr == ADDR_RISE) begin
      rdata_d = rise_q;
    end else if (paddr == ADDR_FALL) begin
      rdata_d = fall_q;
    end else if (paddr == ADDR_STATUS) begin
      rdata_d = {24'h0, bus_cfg_q, strap_done_q, 1'b0, pg_q, drv_q, st_q};
    end else if (paddr == ADDR_GAIN) begin
      rdata_d = {16'h0, gain_q};
    end
  end
  assign prdata = rdata_d;

  // sequencer
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    vref_d = vref_q;
    pg_d = pg_q;
    drv_d = drv_q;
    gain_d = gain_q;
    if (autocomp_q) begin
      gain_d = (st_q == ST_OFF_DLY) ? fall_q[VW-1:0] : rise_q[VW-1:0];
    end
    case (st_q)
      ST_OFF: begin
        vref_d = '0;
        pg_d = 1'b0;
        drv_d = 1'b0;
        cnt_d = 32'h0;
        if (en_sync && strap_done_q) st_d = ST_ON_DLY;
      end
      ST_ON_DLY: begin
        cnt_d = cnt_q + 32'h1;
        if (!en_sync) begin
          st_d = ST_OFF;
        end else if ((trk_en && bus_cfg_q) || cnt_q + 32'h1 >= ton_eff) begin
          st_d = ST_TRACK;
          drv_d = 1'b1;
          cnt_d = 32'h0;
        end
      end
      ST_TRACK: begin
        // no decrease before power good unless always-follow
        if (follow || want > vref_q) vref_d = want;
        if (!trk_en) vref_d = target_q;
        cnt_d = cnt_q + 32'h1; // ramp runs at least the nominal time unless bus-configured
        if (!en_sync) begin
          st_d = ST_OFF_DLY;
          cnt_d = 32'h0;
        end else if (vref_q == lim_val || (limit && vref_q == want)) begin
          if (cnt_q >= RISE_CYC || bus_cfg_q) begin
            st_d = ST_GOOD;
            pg_d = 1'b1;
          end
        end
      end
      ST_GOOD: begin
        vref_d = want;
        if (!trk_en) vref_d = target_q;
        if (!en_sync) begin
          st_d = ST_OFF_DLY;
          cnt_d = 32'h0;
          pg_d = 1'b0;
        end
      end
      ST_OFF_DLY: begin
        vref_d = trk_en ? want : '0;
        pg_d = 1'b0;
        cnt_d = cnt_q + 32'h1;
        if (cnt_q + 32'h1 >= toff_eff || !trk_en) begin
          st_d = ST_OFF;
          drv_d = 1'b0;
          vref_d = '0;
        end
      end
      default: st_d = ST_OFF;
    endcase
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_q <= CFG_RST;
      bus_cfg_q <= 1'b0;
      autocomp_q <= 1'b0;
      target_q <= TARGET_RST;
      ton_q <= 32'h0;
      toff_q <= 32'h0;
      rise_q <= 32'h0;
      fall_q <= 32'h0;
      strap_done_q <= 1'b0;
      st_q <= ST_OFF;
      cnt_q <= 32'h0;
      vref_q <= '0;
      pg_q <= 1'b0;
      drv_q <= 1'b0;
      gain_q <= '0;
    end else if (ce_in) begin
      cfg_q <= cfg_d;
      bus_cfg_q <= bus_cfg_d;
      autocomp_q <= autocomp_d;
      target_q <= target_d;
      ton_q <= ton_d;
      toff_q <= toff_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
      strap_done_q <= strap_done_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      vref_q <= vref_d;
      pg_q <= pg_d;
      drv_q <= drv_d;
      gain_q <= gain_d;
    end
  end

  assign vref_out = vref_q;
  assign drive_on_out = drv_q;
  assign power_good_output = pg_q;
  assign loop_gain_out = gain_q;

  sequence s_off_leave;
    st_q == ST_OFF_DLY && cnt_q + 32'h1 >= toff_eff && ce_in;
  endsequence

  a_off_timeout_forces: assert property (@(posedge clock_in) disable iff (rst_in)
    s_off_leave |=> !drv_q && vref_q == '0)
    else $error("drive not forced off at turn-off timeout");
  a_track_bypass_delay: assert property (@(posedge clock_in) disable iff (rst_in)
    (st_q == ST_ON_DLY && en_sync && trk_en && bus_cfg_q && ce_in) |=> st_q == ST_TRACK)
    else $error("tracking did not skip turn-on delay");
  a_no_enable_before_strap: assert property (@(posedge clock_in) disable iff (rst_in)
    !strap_done_q |-> st_q == ST_OFF)
    else $error("sequence left off before strap sampled");
  a_pg_only_good: assert property (@(posedge clock_in) disable iff (rst_in)
    pg_q |-> st_q == ST_GOOD)
    else $error("power good outside regulation state");
  a_cfg_bus_override: assert property (@(posedge clock_in) disable iff (rst_in)
    (wr_en && paddr == ADDR_TRACK_CFG && ce_in) |=> bus_cfg_q && cfg_q == $past(pwdata[3:0]))
    else $error("bus tracking config not applied");
  a_ref_never_above: assert property (@(posedge clock_in) disable iff (rst_in)
    (st_q == ST_GOOD && trk_en && ce_in) |=> vref_q <= $past(follow_reference_input))
    else $error("reference exceeds tracking input");
  a_autocomp_gain: assert property (@(posedge clock_in) disable iff (rst_in)
    (autocomp_q && st_q == ST_TRACK && ce_in) |=> gain_q == $past(rise_q[VW-1:0]))
    else $error("ramp gain not taken from rise time");
  a_strap_ton_time: assert property (@(posedge clock_in) disable iff (rst_in)
    (st_q == ST_ON_DLY && !bus_cfg_q) |-> cnt_q < TON_CYC)
    else $error("strap turn-on delay overrun");
endmodule

// ===== test/group_partner.sv
// group enable source and reference rail model feeding the tracking input
`timescale 1ns/100ps
module group_partner
  import track_pkg::*;
(
  input  wire logic          clock_in,   // system clock
  output logic               enable_out, // shared group enable
  output logic [VW-1:0]      track_out   // reference rail level
);
  initial begin
    enable_out = 1'b0;
    track_out  = '0;
  end
  // one source drives every enable of the group
  task automatic set_enable(input logic lvl);
    @(posedge clock_in);
    enable_out <= lvl;
  endtask
  // reference rail is untracked and sets the level members follow
  task automatic set_level(input logic [VW-1:0] v);
    @(posedge clock_in);
    track_out <= v;
  endtask
endmodule

// ===== test/supply_tracking_sequencer_test.sv
// self-checking bench for the supply tracking sequencer
`timescale 1ns/100ps
module supply_tracking_sequencer_test;
  import track_pkg::*;
  localparam int TON_C  = 20;
  localparam int TOFF_C = 40;
  localparam int RISE_C = 10;
  localparam logic [VW-1:0] TGT = 16'h1000;
  logic          clock_in, rst_in, ce_in, enable_pin, strap_valid_in;
  logic [2:0]    strap_code_in;
  logic [VW-1:0] track_lvl, vout_sense_in, vref_out, loop_gain_out;
  logic          psel, penable, pwrite, pready, pslverr, drive_on_out, power_good_output;
  logic [7:0]    paddr;
  logic [31:0]   pwdata, prdata, rd;
  int            num_errors, n_tests, n;
  logic          autocomp_on;
  logic [7:0]    ra [5] = '{ADDR_TARGET, ADDR_TON_DLY, ADDR_TOFF_DLY, ADDR_RISE, ADDR_FALL};
  logic [31:0]   rv [5] = '{32'h1000, 32'h14, 32'h28, 32'h0a, 32'h0c};

  supply_tracking_sequencer #(.TON_CYC(TON_C), .TOFF_CYC(TOFF_C), .RISE_CYC(RISE_C))
    i_supply_tracking_sequencer (.clock_in(clock_in), .rst_in(rst_in), .ce_in(ce_in),
    .enable_pin_in(enable_pin), .strap_code_in(strap_code_in), .strap_valid_in(strap_valid_in),
    .follow_reference_input(track_lvl), .vout_sense_in(vout_sense_in), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .vref_out(vref_out), .drive_on_out(drive_on_out),
    .power_good_output(power_good_output), .loop_gain_out(loop_gain_out));
  group_partner i_group_partner (.clock_in(clock_in), .enable_out(enable_pin),
    .track_out(track_lvl));

  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clock_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock_in);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      num_errors++;
      stop_test();
    end
  endtask

  task wait_drive(input logic lvl);
    n = 0;
    while (drive_on_out !== lvl) begin
      @(posedge clock_in);
      n++;
      if (n > 500) begin
        num_errors++;
        stop_test();
      end
    end
  endtask

  // expected reference for ratio / limit settings at tracking level v
  function automatic logic [31:0] exp_ref(input logic r, input logic l, input logic [VW-1:0] v);
    logic [VW-1:0] f, lim;
    f   = r ? (v >> 1) : v;
    lim = r ? (l ? TGT : (TGT >> 1)) : (l ? 16'hffff : TGT);
    return 32'((f < lim) ? f : lim);
  endfunction

  task automatic run_rail(input logic r, input logic l, input logic chk_on);
    logic [VW-1:0] lv [2] = '{16'h0800, 16'h3000};
    i_group_partner.set_level(16'h0000);
    i_group_partner.set_enable(1'b1);
    wait_drive(1'b1);
    if (chk_on) check(32'(n >= TON_C && n <= TON_C + 8), 32'h1);
    else check(32'(n <= 8), 32'h1);
    check(32'(loop_gain_out), autocomp_on ? 32'h0a : 32'h0);
    foreach (lv[i]) begin
      // reference ramps only once the member is driving
      i_group_partner.set_level(lv[i]);
      repeat (8) @(posedge clock_in);
      @(negedge clock_in);
      check(32'(vref_out), exp_ref(r, l, lv[i]));
    end
    check(32'(power_good_output), 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd, {24'h0, !chk_on, 4'hb, 3'(ST_GOOD)});
    i_group_partner.set_enable(1'b0);
    // reference falls well inside the member turn-off delay
    i_group_partner.set_level(16'h0200);
    repeat (8) @(posedge clock_in);
    @(negedge clock_in);
    check(32'(vref_out), exp_ref(r, l, 16'h0200));
    check(32'(power_good_output), 32'h0);
    check(32'(loop_gain_out), autocomp_on ? 32'h0c : 32'h0);
    wait_drive(1'b0);
    check(32'(n + 9 >= TOFF_C && n + 9 <= TOFF_C + 8), 32'h1);
  endtask

  initial begin
    num_errors = 0;
    n_tests = 0;
    autocomp_on = 1'b0;
    rst_in = 1'b1;
    ce_in = 1'b1;
    strap_code_in = 3'h0;
    strap_valid_in = 1'b0;
    vout_sense_in = '0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    @(negedge clock_in);
    check({pready, pslverr, drive_on_out, power_good_output}, 32'h8);
    check(32'(vref_out), 32'h0);
    apb(1'b0, ADDR_TARGET, 32'h0);
    check(rd, 32'(TARGET_RST));
    apb(1'b0, ADDR_TRACK_CFG, 32'h0);
    check(rd, 32'(CFG_RST));
    apb(1'b1, 8'h24, 32'h1234);
    apb(1'b0, 8'h24, 32'h0);
    check(rd, 32'h0);
    foreach (ra[i]) apb(1'b1, ra[i], rv[i]);
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0);
      check({16'h0, rd[15:0]}, rv[i]);
    end
    // strap 121k: full ratio, limited by input, always follows
    strap_code_in <= 3'h3;
    strap_valid_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    run_rail(1'b0, 1'b1, 1'b1);
    apb(1'b1, ADDR_CTRL, 32'h1);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd, 32'h1);
    autocomp_on = 1'b1;
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, ADDR_TRACK_CFG, {28'h0, 1'b1, 2'(m), 1'b1});
      run_rail(m[0], m[1], 1'b0);
    end
    stop_test();
  end
endmodule
